// File: common/frac_n_pkg.sv
`default_nettype none
package frac_n_pkg;

  localparam int WORD_W = 24;

  // tuning word layout, lsb pair 00
  typedef struct packed {
    logic       direction_select;
    logic       power_down;
    logic       fast_lock;
    logic       spare_zero;
    logic       band_select;
    logic [3:0] program_count;
    logic [2:0] swallow_count;
    logic [9:0] frac_numerator;
    logic [1:0] addr;
  } tuning_word_s;

  // synth configuration word layout, lsb pair 01
  typedef struct packed {
    logic        default_word_select;
    logic [15:0] fixed_pattern;
    logic        lock_detect_enable;
    logic [1:0]  out_buffer_level;
    logic [1:0]  ref_freq_select;
    logic [1:0]  addr;
  } synth_config_word_s;

  // decoded settings handed to the loop
  typedef struct packed {
    logic [6:0] n_integer;
    logic [9:0] frac_numerator;
    logic [9:0] frac_denominator;
    logic [1:0] ref_div;
    logic       band_select;
    logic       direction_select;
    logic       power_down;
    logic       fast_lock;
    logic [1:0] out_buffer_level;
  } synth_settings_s;

  typedef logic [9:0] fd_t;

  // word addresses
  localparam logic [1:0] ADDR_TUNING = 2'h0;
  localparam logic [1:0] ADDR_CONFIG = 2'h1;
  localparam logic [1:0] ADDR_WORD3  = 2'h2;
  localparam int         EXT_WORDS   = 3;
  localparam logic [4:0] EXT_ADDR [0:2] = '{5'h03, 5'h07, 5'h0F};
  localparam logic [4:0] EXT_MASK [0:2] = '{5'h07, 5'h0F, 5'h1F};

  // values after reset and built-in contents
  localparam logic [23:0] TUNING_RESET  = 24'h010000;
  localparam logic [23:0] CONFIG_RESET  = 24'h928101;
  localparam logic [23:0] WORD3_DEFAULT = 24'hC87806;
  localparam logic [23:0] EXT_DEFAULT [0:2] = '{24'h86801B, 24'h03A327, 24'h00000F};

  // reference selection codes
  localparam logic [1:0] REF_12M6 = 2'h0;
  localparam logic [1:0] REF_14M4 = 2'h1;
  localparam logic [1:0] REF_25M2 = 2'h2;
  localparam logic [1:0] REF_26M0 = 2'h3;

  localparam logic [1:0] REF_DIV_LOW  = 2'h1;
  localparam logic [1:0] REF_DIV_HIGH = 2'h2;
  localparam logic [3:0] MULT_UPPER   = 4'h8;
  localparam logic [3:0] MULT_LOWER   = 4'h4;

  // denominators indexed by reference code
  localparam fd_t FD_RX    [0:3] = '{10'h1F8, 10'h240, 10'h1F8, 10'h208};
  localparam fd_t FD_TX_LO [0:3] = '{10'h276, 10'h2D0, 10'h276, 10'h28A};
  localparam fd_t FD_TX_HI [0:3] = '{10'h237, 10'h288, 10'h237, 10'h249};

endpackage
`default_nettype wire

// File: hdl/fd_lookup.sv
`default_nettype none
module fd_lookup (
  // mode selection
  input  wire logic       direction_select,
  input  wire logic       band_select,
  input  wire logic [1:0] ref_freq_select,
  // results
  output logic [9:0]      frac_denominator,
  output logic [1:0]      ref_div
);

  // fd equals fosc over ref_div times spacing, tabulated
  always_comb begin
    if (ref_freq_select == frac_n_pkg::REF_25M2 ||
        ref_freq_select == frac_n_pkg::REF_26M0) begin
      ref_div = frac_n_pkg::REF_DIV_HIGH;
    end else begin
      ref_div = frac_n_pkg::REF_DIV_LOW;
    end
    case ({direction_select, band_select})
      2'h2:    frac_denominator = frac_n_pkg::FD_TX_LO[ref_freq_select];
      2'h3:    frac_denominator = frac_n_pkg::FD_TX_HI[ref_freq_select];
      default: frac_denominator = frac_n_pkg::FD_RX[ref_freq_select];
    endcase
  end

endmodule
`default_nettype wire

// File: hdl/frac_n_divider_config.sv
`default_nettype none
// Summary of operation
// - upper band: n = 8*program+swallow+fraction
// - lower band: n = 4*program+swallow+fraction
// - denominator is fosc over r times spacing
// - reference code picks 12.6/14.4/25.2/26.0 MHz
// - reference divider 1 for 00/01, else 2
// - receive: denominators 504/576/504/520
// - transmit lower: denominators 630/720/630/650
// - transmit upper: denominators 567/648/567/585
// - lsb pair 01 routes to configuration
// - default select uses built-in extended words
// - extended words written only without default
// - lock pin grounded unless enabled
// - buffer level code monotonic, 00 min
// - band_select 1 upper, 0 lower law
// - direction 0 receive, 1 transmit
// - lsb pair 00 routes to tuning word
module frac_n_divider_config (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // three-wire serial link
  input  wire logic                        ser_clk,
  input  wire logic                        ser_data,
  input  wire logic                        ser_le,
  // raw lock indication from the loop
  input  wire logic                        lock_raw,
  // decoded settings
  output frac_n_pkg::synth_settings_s      settings,
  output logic [3:0][23:0]                 aux_word,
  output logic                             lock_detect_pin
);

  // synchronisers
  logic clk_meta;
  logic clk_sync;
  logic clk_prev;
  logic le_meta;
  logic le_sync;
  logic le_prev;
  logic data_meta;
  logic data_sync;
  logic lock_meta;
  logic lock_sync;
  logic settled;
  logic next_settled;
  logic next_clk_meta;
  logic next_clk_sync;
  logic next_clk_prev;
  logic next_le_meta;
  logic next_le_sync;
  logic next_le_prev;
  logic next_data_meta;
  logic next_data_sync;
  logic next_lock_meta;
  logic next_lock_sync;

  always_comb begin
    next_clk_meta  = ser_clk;
    next_clk_sync  = clk_meta;
    next_clk_prev  = clk_sync;
    next_le_meta   = ser_le;
    next_le_sync   = le_meta;
    next_le_prev   = le_sync;
    next_data_meta = ser_data;
    next_data_sync = data_meta;
    next_lock_meta = lock_raw;
    next_lock_sync = lock_meta;
    next_settled   = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clk_meta  <= 1'b0;
      clk_sync  <= 1'b0;
      clk_prev  <= 1'b0;
      // latch enable idles high, so no false commit out of reset
      le_meta   <= 1'b1;
      le_sync   <= 1'b1;
      le_prev   <= 1'b1;
      data_meta <= 1'b0;
      data_sync <= 1'b0;
      lock_meta <= 1'b0;
      lock_sync <= 1'b0;
      settled   <= 1'b0;
    end else begin
      clk_meta  <= next_clk_meta;
      clk_sync  <= next_clk_sync;
      clk_prev  <= next_clk_prev;
      le_meta   <= next_le_meta;
      le_sync   <= next_le_sync;
      le_prev   <= next_le_prev;
      data_meta <= next_data_meta;
      data_sync <= next_data_sync;
      lock_meta <= next_lock_meta;
      lock_sync <= next_lock_sync;
      settled   <= next_settled;
    end
  end

  logic clk_rise;
  logic le_rise;
  assign clk_rise = clk_sync & ~clk_prev;
  assign le_rise  = le_sync & ~le_prev;

  // shift register, msb first, while latch enable is low
  logic [23:0] shift;
  logic [23:0] next_shift;

  always_comb begin
    next_shift = shift;
    if (clk_rise && !le_sync) begin
      next_shift = {shift[22:0], data_sync};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift <= 24'h000000;
    end else begin
      shift <= next_shift;
    end
  end

  // control words
  frac_n_pkg::tuning_word_s       tuning;
  frac_n_pkg::tuning_word_s       next_tuning;
  frac_n_pkg::synth_config_word_s config_word;
  frac_n_pkg::synth_config_word_s next_config_word;
  logic [23:0]                    word3;
  logic [23:0]                    next_word3;

  always_comb begin
    next_tuning      = tuning;
    next_config_word = config_word;
    next_word3       = word3;
    if (le_rise) begin
      case (shift[1:0])
        frac_n_pkg::ADDR_TUNING: next_tuning      = shift;
        frac_n_pkg::ADDR_CONFIG: next_config_word = shift;
        frac_n_pkg::ADDR_WORD3:  next_word3       = shift;
        default:                 next_word3       = word3;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tuning      <= frac_n_pkg::TUNING_RESET;
      config_word <= frac_n_pkg::CONFIG_RESET;
      word3       <= frac_n_pkg::WORD3_DEFAULT;
    end else begin
      tuning      <= next_tuning;
      config_word <= next_config_word;
      word3       <= next_word3;
    end
  end

  // extended words, one entry each
  logic [2:0][23:0] ext_word;
  logic [2:0][23:0] ext_eff;

  genvar i;
  generate
    for (i = 0; i < frac_n_pkg::EXT_WORDS; i++) begin : g_ext
      logic [23:0] next_ext;
      logic        hit;
      assign hit = le_rise && !config_word.default_word_select &&
                   ((shift[4:0] & frac_n_pkg::EXT_MASK[i]) == frac_n_pkg::EXT_ADDR[i]);
      always_comb begin
        next_ext = hit ? shift : ext_word[i];
      end
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          ext_word[i] <= frac_n_pkg::EXT_DEFAULT[i];
        end else begin
          ext_word[i] <= next_ext;
        end
      end
      // built-in contents while default selected
      assign ext_eff[i] = config_word.default_word_select ?
                          frac_n_pkg::EXT_DEFAULT[i] : ext_word[i];
    end
  endgenerate

  // denominator and reference divider
  logic [9:0] fd_value;
  logic [1:0] ref_div_value;

  fd_lookup u_fd_lookup (
    .direction_select (tuning.direction_select),
    .band_select      (tuning.band_select),
    .ref_freq_select  (config_word.ref_freq_select),
    .frac_denominator (fd_value),
    .ref_div          (ref_div_value)
  );

  // output settings
  logic [3:0]                  multiplier;
  logic [6:0]                  product;
  frac_n_pkg::synth_settings_s next_settings;
  logic [3:0][23:0]            next_aux_word;
  logic                        next_lock_detect_pin;

  always_comb begin
    multiplier = tuning.band_select ? frac_n_pkg::MULT_UPPER
                                    : frac_n_pkg::MULT_LOWER;
    product    = {3'h0, multiplier} * {3'h0, tuning.program_count};
    next_settings.n_integer        = product + {4'h0, tuning.swallow_count};
    next_settings.frac_numerator   = tuning.frac_numerator;
    next_settings.frac_denominator = fd_value;
    next_settings.ref_div          = ref_div_value;
    next_settings.band_select      = tuning.band_select;
    next_settings.direction_select = tuning.direction_select;
    next_settings.power_down       = tuning.power_down;
    next_settings.fast_lock        = tuning.fast_lock;
    next_settings.out_buffer_level = config_word.out_buffer_level;
    next_aux_word        = {ext_eff, word3};
    next_lock_detect_pin = config_word.lock_detect_enable & lock_sync;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      settings        <= '0;
      aux_word        <= '0;
      lock_detect_pin <= 1'b0;
    end else begin
      settings        <= next_settings;
      aux_word        <= next_aux_word;
      lock_detect_pin <= next_lock_detect_pin;
    end
  end

  // checks, held off until the first edge out of reset
  sequence s_commit_config;
    le_rise && shift[1:0] == frac_n_pkg::ADDR_CONFIG;
  endsequence

  sequence s_commit_tuning;
    le_rise && shift[1:0] == frac_n_pkg::ADDR_TUNING;
  endsequence

  sequence s_commit_ext_blocked;
    le_rise && config_word.default_word_select && shift[1:0] == 2'h3;
  endsequence

  property p_law_upper;
    @(posedge clk) disable iff (!rst_n || !settled)
    tuning.band_select |=> settings.n_integer ==
      (({3'h0, $past(tuning.program_count)} << 3) + {4'h0, $past(tuning.swallow_count)});
  endproperty
  a_law_upper: assert property (p_law_upper) else $error("upper band n wrong");

  property p_law_lower;
    @(posedge clk) disable iff (!rst_n || !settled)
    !tuning.band_select |=> settings.n_integer ==
      (({3'h0, $past(tuning.program_count)} << 2) + {4'h0, $past(tuning.swallow_count)});
  endproperty
  a_law_lower: assert property (p_law_lower) else $error("lower band n wrong");

  property p_ref_div;
    @(posedge clk) disable iff (!rst_n || !settled)
    ##1 settings.ref_div == ($past(config_word.ref_freq_select[1]) ? 2'h2 : 2'h1);
  endproperty
  a_ref_div: assert property (p_ref_div) else $error("reference divider wrong");

  property p_fd_rx;
    @(posedge clk) disable iff (!rst_n || !settled)
    !tuning.direction_select |=>
      settings.frac_denominator == frac_n_pkg::FD_RX[$past(config_word.ref_freq_select)];
  endproperty
  a_fd_rx: assert property (p_fd_rx) else $error("receive denominator wrong");

  property p_fd_tx_lo;
    @(posedge clk) disable iff (!rst_n || !settled)
    tuning.direction_select && !tuning.band_select |=>
      settings.frac_denominator == frac_n_pkg::FD_TX_LO[$past(config_word.ref_freq_select)];
  endproperty
  a_fd_tx_lo: assert property (p_fd_tx_lo) else $error("tx lower denominator wrong");

  property p_fd_tx_hi;
    @(posedge clk) disable iff (!rst_n || !settled)
    tuning.direction_select && tuning.band_select |=>
      settings.frac_denominator == frac_n_pkg::FD_TX_HI[$past(config_word.ref_freq_select)];
  endproperty
  a_fd_tx_hi: assert property (p_fd_tx_hi) else $error("tx upper denominator wrong");

  property p_config_route;
    @(posedge clk) disable iff (!rst_n || !settled)
    s_commit_config |=> config_word == $past(shift) ##1
      settings.out_buffer_level == $past(shift[5:4], 2);
  endproperty
  a_config_route: assert property (p_config_route) else $error("config word not taken");

  property p_tuning_route;
    @(posedge clk) disable iff (!rst_n || !settled)
    s_commit_tuning |=> tuning == $past(shift) && $stable(config_word);
  endproperty
  a_tuning_route: assert property (p_tuning_route) else $error("tuning word not taken");

  property p_ext_blocked;
    @(posedge clk) disable iff (!rst_n || !settled)
    s_commit_ext_blocked |=> $stable(ext_word);
  endproperty
  a_ext_blocked: assert property (p_ext_blocked) else $error("extended word written");

  property p_ext_default;
    @(posedge clk) disable iff (!rst_n || !settled)
    config_word.default_word_select |=> aux_word[1] == frac_n_pkg::EXT_DEFAULT[0] &&
      aux_word[3] == frac_n_pkg::EXT_DEFAULT[2];
  endproperty
  a_ext_default: assert property (p_ext_default) else $error("defaults not in use");

  property p_lock_gnd;
    @(posedge clk) disable iff (!rst_n || !settled)
    !config_word.lock_detect_enable |=> !lock_detect_pin;
  endproperty
  a_lock_gnd: assert property (p_lock_gnd) else $error("lock pin not grounded");

  property p_lock_follow;
    @(posedge clk) disable iff (!rst_n || !settled)
    config_word.lock_detect_enable |=> lock_detect_pin == $past(lock_sync);
  endproperty
  a_lock_follow: assert property (p_lock_follow) else $error("lock pin not following");

endmodule
`default_nettype wire

// File: bench/host_serial_model.sv
`default_nettype none
module host_serial_model (
  // system clock
  input  wire logic clk,
  // three-wire serial link
  output logic      ser_clk,
  output logic      ser_data,
  output logic      ser_le
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    ser_clk  = 1'b0;
    ser_data = 1'b0;
    ser_le   = 1'b1;
  end

  // shifts one word msb first, commits it on latch rise
  task automatic send_word(input logic [23:0] w);
    @(posedge clk);
    ser_le <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      ser_data <= w[i];
      ser_clk  <= 1'b0;
      repeat (3) @(posedge clk);
      ser_clk <= 1'b1;
      repeat (3) @(posedge clk);
    end
    // shift clock stands low, released data shows the inverse
    ser_clk  <= 1'b0;
    ser_data <= ~w[0];
    repeat (3) @(posedge clk);
    ser_le <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// File: bench/frac_n_divider_config_test.sv
`default_nettype none
module frac_n_divider_config_test;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {
    int          kind;
    int          idx;
    logic [37:0] val;
  } note_s;

  logic                        clk, rst_n, ser_clk, ser_data, ser_le, lock_raw;
  logic                        lock_detect_pin, req, dir, band, ld;
  frac_n_pkg::synth_settings_s settings, exp_set;
  logic [3:0][23:0]            aux_word;
  logic [31:0]                 seed, r;
  logic [1:0]                  rf, obl;
  logic [3:0]                  prog;
  logic [2:0]                  sw;
  logic [9:0]                  num, fd;
  int                          fails, check_count;
  note_s                       notes[$];
  note_s                       cur;
  logic [9:0]                  fd_tab [0:11] = '{10'h1F8, 10'h240, 10'h1F8, 10'h208,
                                                 10'h276, 10'h2D0, 10'h276, 10'h28A,
                                                 10'h237, 10'h288, 10'h237, 10'h249};

  frac_n_divider_config DUT (
    .clk             (clk),
    .rst_n           (rst_n),
    .ser_clk         (ser_clk),
    .ser_data        (ser_data),
    .ser_le          (ser_le),
    .lock_raw        (lock_raw),
    .settings        (settings),
    .aux_word        (aux_word),
    .lock_detect_pin (lock_detect_pin)
  );

  host_serial_model host (
    .clk      (clk),
    .ser_clk  (ser_clk),
    .ser_data (ser_data),
    .ser_le   (ser_le)
  );

  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic tally(input logic [37:0] e, input logic [37:0] g);
    check_count++;
    if (e !== g) begin
      fails++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic cmp_settings(input logic [37:0] e);
    tally(e, settings);
  endtask

  task automatic cmp_aux(input int k, input logic [23:0] e);
    tally({14'h0, e}, {14'h0, aux_word[k]});
  endtask

  task automatic cmp_lock(input logic e);
    tally({37'h0, e}, {37'h0, lock_detect_pin});
  endtask

  task automatic note_it(input int kind, input int idx, input logic [37:0] val);
    notes.push_back('{kind, idx, val});
  endtask

  // let the word pass the synchronisers, then ask the watcher to compare
  task automatic settle();
    repeat (8) @(posedge clk);
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    if (req) begin
      while (notes.size() > 0) begin
        cur = notes.pop_front();
        case (cur.kind)
          0: cmp_settings(cur.val);
          1: cmp_aux(cur.idx, cur.val[23:0]);
          default: cmp_lock(cur.val[0]);
        endcase
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    #2000000;
    fails++;
    summarize();
  end

  initial begin
    rst_n    = 1'b0;
    lock_raw = 1'b0;
    req      = 1'b0;
    seed     = 32'h863EA0BD;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    note_it(0, 0, {7'h08, 10'h000, 10'h1F8, 2'h1, 6'h00});
    for (int k = 1; k < 4; k++) begin
      note_it(1, k, {14'h0, frac_n_pkg::EXT_DEFAULT[k-1]});
    end
    note_it(2, 0, 38'h0);
    settle();
    // every direction, band and reference code, random counters
    for (int i = 0; i < 16; i++) begin
      r    = xorshift();
      dir  = i[3];
      band = i[2];
      rf   = i[1:0];
      ld   = r[0];
      obl  = r[2:1];
      prog = 4'h2 + 4'(r[7:4] % 14);
      sw   = band ? r[10:8] : {1'b0, r[9:8]};
      if ({1'b0, sw} >= prog) begin
        sw = 3'(prog - 4'h1);
      end
      fd   = fd_tab[(dir ? (band ? 8 : 4) : 0) + int'(rf)];
      num  = 10'(r[25:16] % fd);
      lock_raw <= r[31];
      host.send_word({1'b1, 16'h2502, ld, obl, rf, 2'h1});
      host.send_word({dir, r[11], r[12], 1'b0, band, prog, sw, num, 2'h0});
      exp_set = {7'((band ? 8 : 4) * prog + sw), num, fd, (rf[1] ? 2'h2 : 2'h1),
                 band, dir, r[11], r[12], obl};
      note_it(0, 0, exp_set);
      note_it(2, 0, {37'h0, ld & r[31]});
      settle();
    end
    // third word and a blocked extended write leave the settings alone
    host.send_word(24'hA5A5A6);
    host.send_word(24'h5A5A5B);
    note_it(1, 0, {14'h0, 24'hA5A5A6});
    note_it(1, 1, {14'h0, 24'h86801B});
    note_it(0, 0, exp_set);
    settle();
    // default off: the blocked write must not show, then programmed words apply
    host.send_word({1'b0, 16'h2502, 1'b0, 2'h0, 2'h0, 2'h1});
    note_it(1, 1, {14'h0, frac_n_pkg::EXT_DEFAULT[0]});
    note_it(2, 0, 38'h0);
    settle();
    host.send_word(24'h5A5A5B);
    host.send_word(24'h123457);
    host.send_word(24'hABCDEF);
    note_it(1, 1, {14'h0, 24'h5A5A5B});
    note_it(1, 2, {14'h0, 24'h123457});
    note_it(1, 3, {14'h0, 24'hABCDEF});
    settle();
    host.send_word({1'b1, 16'h2502, 1'b0, 2'h0, 2'h0, 2'h1});
    for (int k = 1; k < 4; k++) begin
      note_it(1, k, {14'h0, frac_n_pkg::EXT_DEFAULT[k-1]});
    end
    settle();
    summarize();
  end
endmodule
`default_nettype wire
